// [eepp_port.v]
// enhanced / extended-capabilities parallel port controller, host side
`timescale 1ns/1ps
`default_nettype none
`include "eepp_map.vh"
module eepp_port #(
  parameter P_TMO_CYC = `EEPP_TMO_CYC,
  parameter P_STB_CYC = `EEPP_STB_CYC,
  parameter P_DEPTH = 16,
  parameter P_AW = 4
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // avalon-mm slave
  input wire [12:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [3:0] i_avs_byteenable,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // cable status inputs
  input wire i_busy,
  input wire i_acknowledge_in_n,
  input wire i_paper_error,
  input wire i_select,
  input wire i_fault_in_n,
  input wire i_port_wait_n,
  // port data lines
  input wire [7:0] i_port_data_lines,
  output reg [7:0] o_port_data_lines,
  output reg o_port_data_lines_oe,
  // cable control outputs
  output reg o_strobe_write_n,
  output reg o_data_strobe_n,
  output reg o_addr_strobe_n,
  output reg o_init_n,
  // dma request
  output reg o_dma_req
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [1:0] E_IDLE = 2'h0;
  localparam [1:0] E_HOLD = 2'h1;
  localparam [1:0] E_STRB = 2'h2;
  localparam [2:0] H_IDLE = 3'h0;
  localparam [2:0] H_SETUP = 3'h1;
  localparam [2:0] H_STRB = 3'h2;
  localparam [2:0] H_HOLD = 3'h3;
  localparam [2:0] H_RACK = 3'h4;
  localparam [2:0] H_RREL = 3'h5;
  // counts cut on purpose to the width of the counters that use them
  localparam integer L_TMO_I = P_TMO_CYC;
  localparam integer L_STB_I = P_STB_CYC;
  localparam integer L_DEPTH_I = P_DEPTH;
  localparam [15:0] L_TMO = L_TMO_I[15:0];
  localparam [7:0] L_STB = L_STB_I[7:0];
  localparam [P_AW:0] L_DEPTH = L_DEPTH_I[P_AW:0];

  // registers
  reg [7:0] data_latch_ff;
  reg [5:0] ctrl_ff;
  reg [4:0] cfgb_ff;
  reg [2:0] mode_ff;
  reg err_en_ff;
  reg dma_en_ff;
  reg svc_ff;
  reg [1:0] opt_ff;
  reg tmo_ff;
  // fifo
  reg [8:0] fifo_mem [0:P_DEPTH-1];
  reg [P_AW-1:0] wptr_ff;
  reg [P_AW-1:0] rptr_ff;
  reg [P_AW:0] cnt_ff;
  // enhanced cycle engine
  reg [1:0] e_state_ff;
  reg [15:0] e_cnt_ff;
  reg e_low_ff;
  reg e_addr_ff;
  reg e_wr_ff;
  reg [7:0] e_byte_ff;
  // fifo handshake engine
  reg [2:0] h_state_ff;
  reg [7:0] h_cnt_ff;
  reg [7:0] h_byte_ff;
  reg h_tag_ff;
  reg [6:0] rle_ff;
  reg rle_pend_ff;
  reg [6:0] rep_ff;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  wire [10:0] idx = i_avs_address[12:2];
  wire epp_on = (mode_ff == `EEPP_M_EPP) & opt_ff[`EEPP_OPT_EPP];
  wire dir_eff = ctrl_ff[`EEPP_CTRL_DIR] &
                 (mode_ff != `EEPP_M_STD) & (mode_ff != `EEPP_M_COMPAT_FIFO_PORT);
  wire m_ecp = (mode_ff == `EEPP_M_ECP);
  wire m_compat_fifo_port = (mode_ff == `EEPP_M_COMPAT_FIFO_PORT);
  wire m_test = (mode_ff == `EEPP_M_TEST);
  wire ecp_fwd = m_ecp & ~dir_eff;
  wire ecp_rev = m_ecp & dir_eff;
  wire full = (cnt_ff == L_DEPTH);
  wire empty = (cnt_ff == {(P_AW+1){1'b0}});
  // stale bytes are dropped when leaving the fifo modes
  wire flush = ~(m_compat_fifo_port | m_ecp | m_test);

  ////////////////////////////////////////////////////////////////////////////
  // bus request decode; one access is taken per acknowledge
  wire req = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  wire acc = req & (e_state_ff == E_IDLE);
  wire wr_ok = i_avs_write & i_avs_byteenable[0];
  wire hit_data = (idx == `EEPP_IDX_DATA);
  wire hit_fifo = (idx == `EEPP_IDX_FIFO);
  wire epp_port = epp_on &
                  ((idx == `EEPP_IDX_EPPA) | (idx == `EEPP_IDX_EPPD));
  wire a_wr = hit_data & ecp_fwd;
  wire f_wr = hit_fifo & (m_compat_fifo_port | ecp_fwd | m_test);
  wire fifo_wr = acc & wr_ok & (a_wr | f_wr);
  // a write to a full fifo stalls the master until a byte drains
  wire blocked = fifo_wr & full;
  wire fifo_rd = acc & i_avs_read & hit_fifo & (ecp_rev | m_test) & ~empty;
  wire plain_ack = acc & ~epp_port & ~blocked;
  wire epp_start = acc & epp_port;
  wire wr_reg = plain_ack & wr_ok;

  // enhanced cycle end: normal completion or watchdog
  wire e_active = (e_state_ff != E_IDLE);
  wire e_tmo = e_active & (e_cnt_ff >= L_TMO);
  wire e_fin = (e_state_ff == E_STRB) & e_low_ff & i_port_wait_n;
  wire e_end = e_fin | e_tmo;

  ////////////////////////////////////////////////////////////////////////////
  // handshake engine pushes and pops
  wire h_cap = (h_state_ff == H_RACK) & ~i_acknowledge_in_n & ~full;
  wire h_cap_push = h_cap & i_busy;
  wire h_rep_push = (h_state_ff == H_IDLE) & ecp_rev &
                    (rep_ff != 7'h00) & ~full;
  wire h_push = h_cap_push | h_rep_push;
  wire h_pop = (h_state_ff == H_IDLE) & ~empty & (ecp_fwd |
               (m_compat_fifo_port & ~i_busy));
  wire push = (fifo_wr & ~full) | h_push;
  wire pop = fifo_rd | h_pop;
  wire [8:0] push_d = fifo_wr ? {a_wr, i_avs_writedata[7:0]} :
                      {1'b0, (h_cap_push ? i_port_data_lines : h_byte_ff)};
  wire [8:0] head = fifo_mem[rptr_ff];

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  reg [7:0] rmux;
  always @* begin
    rmux = 8'h00;
    case (idx)
      `EEPP_IDX_DATA: begin
        rmux = i_port_data_lines;
      end
      `EEPP_IDX_STAT: begin
        rmux = {~i_busy, i_acknowledge_in_n, i_paper_error, i_select,
                i_fault_in_n, 3'h7};
        if (epp_on) begin
          rmux[`EEPP_STAT_TMO] = tmo_ff;
        end
      end
      `EEPP_IDX_CTRL: begin
        rmux = {2'h3, ctrl_ff};
      end
      `EEPP_IDX_FIFO: begin
        if (mode_ff == `EEPP_M_CFG) begin
          rmux = `EEPP_CFGA_VAL;
        end else if (fifo_rd) begin
          rmux = head[7:0];
        end else begin
          rmux = 8'h00;
        end
      end
      `EEPP_IDX_CFGB: begin
        rmux = {cfgb_ff, 3'h7};
      end
      `EEPP_IDX_ECR: begin
        rmux = {mode_ff, err_en_ff, dma_en_ff, svc_ff, full, empty};
      end
      `EEPP_IDX_OPT: begin
        rmux = {6'h00, opt_ff};
      end
      default: begin
        rmux = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  // offset decode
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_latch_ff <= 8'h00;
      ctrl_ff <= `EEPP_CTRL_RST;
      cfgb_ff <= `EEPP_CFGB_RST;
      mode_ff <= `EEPP_ECR_RST;
      err_en_ff <= 1'b0;
      dma_en_ff <= 1'b0;
      svc_ff <= 1'b0;
      opt_ff <= `EEPP_OPT_RST;
      tmo_ff <= 1'b0;
    end else begin
      if (wr_reg & hit_data & (mode_ff == `EEPP_M_STD |
          mode_ff == `EEPP_M_BIDIR | epp_on)) begin
        data_latch_ff <= i_avs_writedata[7:0];
      end
      if (wr_reg & (idx == `EEPP_IDX_CTRL)) begin
        ctrl_ff <= i_avs_writedata[5:0];
      end
      if (wr_reg & (idx == `EEPP_IDX_CFGB) & (mode_ff == `EEPP_M_CFG)) begin
        cfgb_ff <= i_avs_writedata[7:3];
      end
      if (wr_reg & (idx == `EEPP_IDX_ECR)) begin
        mode_ff <= i_avs_writedata[7:5];
        err_en_ff <= i_avs_writedata[`EEPP_ECR_ERR];
        dma_en_ff <= i_avs_writedata[`EEPP_ECR_DMA];
      end
      // service bit: hardware set beats a software clear
      if (dma_en_ff & ((ecp_rev & full) | ((m_compat_fifo_port | ecp_fwd) & empty))) begin
        svc_ff <= 1'b1;
      end else if (wr_reg & (idx == `EEPP_IDX_ECR)) begin
        svc_ff <= i_avs_writedata[`EEPP_ECR_SVC];
      end
      if (wr_reg & (idx == `EEPP_IDX_OPT)) begin
        opt_ff <= i_avs_writedata[1:0];
      end
      if (e_tmo) begin
        tmo_ff <= 1'b1;
      end else if (wr_reg & (idx == `EEPP_IDX_STAT) &
                   i_avs_writedata[`EEPP_STAT_TMO]) begin
        tmo_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: waitrequest drops for one cycle per taken access
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= ~(plain_ack | e_end);
      if (e_end) begin
        o_avs_readdata <= {24'h00_0000, i_port_data_lines};
      end else if (plain_ack) begin
        o_avs_readdata <= {24'h00_0000, rmux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo storage; memory itself needs no reset
  always @(posedge i_clk_sys) begin
    if (push & ~flush) begin
      fifo_mem[wptr_ff] <= push_d;
    end
  end

  // pointers move on each push and pop; count holds when a push and a pop come in one cycle
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_ff <= {P_AW{1'b0}};
      rptr_ff <= {P_AW{1'b0}};
      cnt_ff <= {(P_AW+1){1'b0}};
    end else if (flush) begin
      wptr_ff <= {P_AW{1'b0}};
      rptr_ff <= {P_AW{1'b0}};
      cnt_ff <= {(P_AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enhanced cycle engine
  // four transfer kinds from port and direction
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      e_state_ff <= E_IDLE;
      e_cnt_ff <= 16'h0000;
      e_low_ff <= 1'b0;
      e_addr_ff <= 1'b0;
      e_wr_ff <= 1'b0;
      e_byte_ff <= 8'h00;
    end else begin
      case (e_state_ff)
        E_IDLE: begin
          e_cnt_ff <= 16'h0000;
          if (epp_start) begin
            e_addr_ff <= (idx == `EEPP_IDX_EPPA);
            e_wr_ff <= wr_ok;
            e_byte_ff <= i_avs_writedata[7:0];
            if (opt_ff[`EEPP_OPT_V17]) begin
              e_low_ff <= 1'b0;
              e_state_ff <= E_STRB;
            // newer version starts with wait low
            end else if (!i_port_wait_n) begin
              e_low_ff <= 1'b1;
              e_state_ff <= E_STRB;
            end else begin
              e_state_ff <= E_HOLD;
            end
          end
        end
        E_HOLD: begin
          e_cnt_ff <= e_cnt_ff + 16'h0001;
          if (e_tmo) begin
            e_state_ff <= E_IDLE;
          end else if (!i_port_wait_n) begin
            e_low_ff <= 1'b1;
            e_state_ff <= E_STRB;
          end
        end
        E_STRB: begin
          e_cnt_ff <= e_cnt_ff + 16'h0001;
          if (!i_port_wait_n) begin
            e_low_ff <= 1'b1;
          end
          if (e_end) begin
            e_state_ff <= E_IDLE;
          end
        end
        default: begin
          e_state_ff <= E_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo handshake engine: printer, burst forward, burst reverse
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h_state_ff <= H_IDLE;
      h_cnt_ff <= 8'h00;
      h_byte_ff <= 8'h00;
      h_tag_ff <= 1'b0;
      rle_ff <= 7'h00;
      rle_pend_ff <= 1'b0;
      rep_ff <= 7'h00;
    end else begin
      case (h_state_ff)
        H_IDLE: begin
          h_cnt_ff <= 8'h00;
          // repeat the byte after a run-length count
          if (h_rep_push) begin
            rep_ff <= rep_ff - 7'h01;
          // drain compatibility or ecp forward fifo by hardware strobe
          end else if (h_pop) begin
            h_byte_ff <= head[7:0];
            h_tag_ff <= head[8];
            h_state_ff <= H_SETUP;
          end else if (ecp_rev & ~full & (rep_ff == 7'h00)) begin
            h_state_ff <= H_RACK;
          end
        end
        H_SETUP: begin
          h_cnt_ff <= h_cnt_ff + 8'h01;
          if (h_cnt_ff >= L_STB - 8'h01) begin
            h_cnt_ff <= 8'h00;
            h_state_ff <= H_STRB;
          end
        end
        H_STRB: begin
          h_cnt_ff <= h_cnt_ff + 8'h01;
          // printer uses a timed strobe, burst mode waits for busy
          if (m_ecp ? i_busy : (h_cnt_ff >= L_STB - 8'h01)) begin
            h_cnt_ff <= 8'h00;
            h_state_ff <= H_HOLD;
          end
        end
        H_HOLD: begin
          h_cnt_ff <= h_cnt_ff + 8'h01;
          if (m_ecp ? ~i_busy : (h_cnt_ff >= L_STB - 8'h01)) begin
            h_state_ff <= H_IDLE;
          end
        end
        H_RACK: begin
          // reverse byte capture; busy low marks a command
          if (h_cap) begin
            h_byte_ff <= i_port_data_lines;
            h_state_ff <= H_RREL;
            if (i_busy & rle_pend_ff) begin
              rep_ff <= rle_ff;
              rle_pend_ff <= 1'b0;
            end else if (~i_busy & ~i_port_data_lines[7]) begin
              rle_ff <= i_port_data_lines[6:0];
              rle_pend_ff <= 1'b1;
            end
          end else if (~ecp_rev) begin
            h_state_ff <= H_IDLE;
          end
        end
        H_RREL: begin
          if (i_acknowledge_in_n) begin
            h_state_ff <= H_IDLE;
          end
        end
        default: begin
          h_state_ff <= H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cable pin drive, all registered
  wire h_fwd = (h_state_ff == H_SETUP) | (h_state_ff == H_STRB) |
               (h_state_ff == H_HOLD);
  wire e_strb = (e_state_ff == E_STRB);
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_data_lines <= 8'h00;
      o_port_data_lines_oe <= 1'b0;
      o_strobe_write_n <= 1'b1;
      o_data_strobe_n <= 1'b1;
      o_addr_strobe_n <= 1'b1;
      o_init_n <= 1'b0;
      o_dma_req <= 1'b0;
    end else begin
      o_init_n <= ctrl_ff[2];
      o_dma_req <= dma_en_ff & (((m_compat_fifo_port | ecp_fwd) & ~full) |
                   (ecp_rev & ~empty));
      // write-select and strobes during a cycle
      if (e_active) begin
        o_port_data_lines <= e_byte_ff;
        o_port_data_lines_oe <= e_wr_ff;
        o_strobe_write_n <= ~e_wr_ff;
        o_data_strobe_n <= ~(e_strb & ~e_addr_ff & ~e_tmo);
        o_addr_strobe_n <= ~(e_strb & e_addr_ff & ~e_tmo);
      end else if (h_fwd) begin
        o_port_data_lines <= h_byte_ff;
        o_port_data_lines_oe <= 1'b1;
        o_strobe_write_n <= (h_state_ff != H_STRB);
        // host ack level marks data high, command low
        o_data_strobe_n <= m_ecp ? ~h_tag_ff : ~ctrl_ff[1];
        o_addr_strobe_n <= ~ctrl_ff[3];
      end else if (ecp_rev) begin
        o_port_data_lines <= data_latch_ff;
        o_port_data_lines_oe <= 1'b0;
        o_strobe_write_n <= ~ctrl_ff[0];
        o_data_strobe_n <= (h_state_ff != H_RACK);
        o_addr_strobe_n <= ~ctrl_ff[3];
      end else begin
        o_port_data_lines <= data_latch_ff;
        o_port_data_lines_oe <= ~dir_eff;
        o_strobe_write_n <= ~ctrl_ff[0];
        o_data_strobe_n <= ~ctrl_ff[1];
        o_addr_strobe_n <= ~ctrl_ff[3];
      end
    end
  end

endmodule
`default_nettype wire

// [eepp_map.vh]
// register indices, field positions, reset values and timing for the port
`ifndef EEPP_MAP_VH
`define EEPP_MAP_VH
// register indices; byte address on the bus is four times the index
`define EEPP_IDX_DATA 11'h000
`define EEPP_IDX_STAT 11'h001
`define EEPP_IDX_CTRL 11'h002
`define EEPP_IDX_EPPA 11'h003
`define EEPP_IDX_EPPD 11'h004
`define EEPP_IDX_FIFO 11'h400
`define EEPP_IDX_CFGB 11'h401
`define EEPP_IDX_ECR 11'h402
`define EEPP_IDX_OPT 11'h403
// port mode codes
`define EEPP_M_STD 3'h0
`define EEPP_M_BIDIR 3'h1
`define EEPP_M_COMPAT_FIFO_PORT 3'h2
`define EEPP_M_ECP 3'h3
`define EEPP_M_EPP 3'h4
`define EEPP_M_TEST 3'h6
`define EEPP_M_CFG 3'h7
// field positions
`define EEPP_CTRL_DIR 5
`define EEPP_ECR_ERR 4
`define EEPP_ECR_DMA 3
`define EEPP_ECR_SVC 2
`define EEPP_STAT_TMO 0
`define EEPP_OPT_EPP 0
`define EEPP_OPT_V17 1
// fixed and reset values
`define EEPP_CFGA_VAL 8'h10
`define EEPP_CFGB_RST 5'h00
`define EEPP_CTRL_RST 6'h00
`define EEPP_ECR_RST 3'h0
`define EEPP_OPT_RST 2'h0
// timing
`define EEPP_CLK_NS 10
`define EEPP_TMO_NS 10000
`define EEPP_STB_NS 500
`define EEPP_TMO_CYC (`EEPP_TMO_NS / `EEPP_CLK_NS)
`define EEPP_STB_CYC ((`EEPP_STB_NS + `EEPP_CLK_NS - 1) / `EEPP_CLK_NS)
`endif

// [eepp_props.sv]
// assertions on the port controller's bus and cable pins
`timescale 1ns/1ps
`default_nettype none
module eepp_props #(
  parameter P_TMO_CYC = 1000
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // register bus
  input wire logic [12:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // cable
  input wire logic i_busy,
  input wire logic i_acknowledge_in_n,
  input wire logic i_paper_error,
  input wire logic i_select,
  input wire logic i_fault_in_n,
  input wire logic i_port_wait_n,
  input wire logic o_port_data_lines_oe,
  input wire logic o_data_strobe_n,
  input wire logic o_addr_strobe_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  wire [10:0] idx;
  wire epp;
  wire stb;
  logic [15:0] stall_ff;
  // an enhanced-port access pending, and a cable strobe active
  assign idx = i_avs_address[12:2];
  assign epp = (idx == 11'h003 || idx == 11'h004) &&
    (i_avs_read || i_avs_write);
  assign stb = !(o_data_strobe_n && o_addr_strobe_n);
  // stall length of an enhanced access; the watchdog must cut it short
  always @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n) stall_ff <= 16'h0000;
    else if (epp && o_avs_waitrequest) stall_ff <= stall_ff + 16'h0001;
    else stall_ff <= 16'h0000;
  a_ack_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer held over one cycle");
  a_ack_cause: assert property (!o_avs_waitrequest |->
    $past(i_avs_read || i_avs_write)) else $error("answer without request");
  a_rdata_upper: assert property (!o_avs_waitrequest |->
    o_avs_readdata[31:8] == 24'h000000) else $error("upper data not zero");
  a_status_map: assert property (
    i_avs_read && idx == 11'h001 && !o_avs_waitrequest |->
    o_avs_readdata[7:1] == {!$past(i_busy), $past(i_acknowledge_in_n),
    $past(i_paper_error), $past(i_select), $past(i_fault_in_n), 2'b11})
    else $error("status bits wrong");
  a_tmo_bound: assert property (stall_ff <= P_TMO_CYC + 4)
    else $error("enhanced cycle not aborted");
  a_wait_end: assert property (
    epp && o_avs_waitrequest && stb && $rose(i_port_wait_n) |->
    ##[1:3] !o_avs_waitrequest) else $error("cycle not ended on wait");
  a_wr_drive: assert property (
    epp && i_avs_write && stb |-> o_port_data_lines_oe)
    else $error("write cycle lines not driven");
  a_rd_float: assert property (
    epp && i_avs_read && stb |-> !o_port_data_lines_oe)
    else $error("read cycle lines driven");
  c_epp_done: cover property (epp && !o_avs_waitrequest);
  c_tmo: cover property (stall_ff == P_TMO_CYC);
  c_rd_cyc: cover property (epp && i_avs_read && stb);
endmodule
bind eepp_port eepp_props #(.P_TMO_CYC(P_TMO_CYC)) props_u (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_busy(i_busy), .i_acknowledge_in_n(i_acknowledge_in_n),
  .i_paper_error(i_paper_error), .i_select(i_select),
  .i_fault_in_n(i_fault_in_n), .i_port_wait_n(i_port_wait_n),
  .o_port_data_lines_oe(o_port_data_lines_oe),
  .o_data_strobe_n(o_data_strobe_n), .o_addr_strobe_n(o_addr_strobe_n));
`default_nettype wire

// [eepp_periph.sv]
// enhanced-mode peripheral on the cable side of the port
`timescale 1ns/1ps
`default_nettype none
module eepp_periph (
  // clock
  input wire logic i_clk_sys,
  // host pins
  input wire logic i_ds_n,
  input wire logic i_as_n,
  input wire logic i_wr_n,
  input wire logic i_oe,
  input wire logic [7:0] i_dout,
  // misbehaviour and answer controls
  input wire logic i_hold,
  input wire logic i_mute,
  input wire logic [3:0] i_dly,
  input wire logic [7:0] i_rbyte,
  // peripheral pins and capture
  output logic o_wait_n,
  output logic [7:0] o_lines,
  output logic [7:0] o_cap,
  output logic o_cap_a
);
  logic [4:0] cnt_ff = 5'h00;
  logic wait_ff = 1'b0;
  logic [7:0] cap_ff = 8'h00;
  logic kind_ff = 1'b0;
  // wait rises a set delay after a strobe, falls when it ends
  always @(posedge i_clk_sys) begin
    if (i_hold) begin
      wait_ff <= 1'b1;
      cnt_ff <= 5'h00;
    end else if (!(i_ds_n && i_as_n) && !i_mute) begin
      if (cnt_ff != 5'h1f) cnt_ff <= cnt_ff + 5'h01;
      wait_ff <= (cnt_ff >= {1'b0, i_dly});
      if (cnt_ff == {1'b0, i_dly} && !i_wr_n) begin
        cap_ff <= i_dout;
        kind_ff <= !i_as_n;
      end
    end else begin
      wait_ff <= 1'b0;
      cnt_ff <= 5'h00;
    end
  end
  // the peripheral drives its byte whenever the host lets go
  assign o_lines = i_oe ? i_dout : i_rbyte;
  assign o_wait_n = wait_ff;
  assign o_cap = cap_ff;
  assign o_cap_a = kind_ff;
endmodule
`default_nettype wire

// [epp_ecp_parallel_port_bench.sv]
// self-checking bench for the parallel port controller
`timescale 1ns/1ps
`default_nettype none
module epp_ecp_parallel_port_bench;
  logic clk, rst_n, rd, wr, busy, ack_n, perr, sel, flt_n, hold, mute;
  logic [12:0] addr;
  logic [31:0] wd;
  logic [7:0] q, rbyte;
  wire [31:0] rdata;
  wire [7:0] pdo, pdi, cap;
  wire wq, oe, stw_n, ds_n, as_n, wt_n, cap_a, dreq, init_n;
  int miscompares, comparisons, lat;
  eepp_port #(.P_TMO_CYC(20), .P_STB_CYC(2)) dut_u (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'h1),
    .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
    .i_busy(busy), .i_acknowledge_in_n(ack_n), .i_paper_error(perr),
    .i_select(sel), .i_fault_in_n(flt_n), .i_port_wait_n(wt_n),
    .i_port_data_lines(pdi), .o_port_data_lines(pdo),
    .o_port_data_lines_oe(oe), .o_strobe_write_n(stw_n),
    .o_data_strobe_n(ds_n), .o_addr_strobe_n(as_n), .o_init_n(init_n),
    .o_dma_req(dreq));
  eepp_periph peer_u (.i_clk_sys(clk), .i_ds_n(ds_n), .i_as_n(as_n),
    .i_wr_n(stw_n), .i_oe(oe), .i_dout(pdo), .i_hold(hold),
    .i_mute(mute), .i_dly(4'h2), .i_rbyte(rbyte), .o_wait_n(wt_n),
    .o_lines(pdi), .o_cap(cap), .o_cap_a(cap_a));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one bus access: hold the request until waitrequest is sampled low
  task bus(input logic w, input logic [10:0] x, input logic [7:0] d,
    output logic [7:0] r);
    lat = 0;
    addr <= {x, 2'b00};
    wd <= {24'h000000, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      lat++;
    end while (wq !== 1'b0 && lat < 200);
    r = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (lat >= 200) begin
      miscompares++;
      conclude();
    end
  endtask
  task wrr(input logic [10:0] x, input logic [7:0] d);
    bus(1'b1, x, d, q);
  endtask
  task rdc(input string nm, input logic [10:0] x, input logic [7:0] e);
    bus(1'b0, x, 8'h00, q);
    chk(nm, q, e);
  endtask
  task done(input string t);
    $display("test %s done", t);
  endtask
  // bounded wait for the printer strobe pin to be sampled low
  task stb_wait();
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (stw_n !== 1'b0 && lat < 200);
    if (lat >= 200) begin
      miscompares++;
      conclude();
    end
  endtask
  initial begin
    {rd, wr, hold, mute, rst_n} = 5'b00000;
    {busy, ack_n, perr, sel, flt_n} = 5'b01011;
    addr = 13'h0000;
    wd = 32'h00000000;
    rbyte = 8'h3c;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc("ctrl", 11'h002, 8'hc0);
    rdc("ecr", 11'h402, 8'h01);
    rdc("stat", 11'h001, 8'hdf);
    {busy, ack_n, perr, sel, flt_n} <= 5'b10101;
    @(posedge clk);
    rdc("stat", 11'h001, 8'h2f);
    rdc("unmapped", 11'h005, 8'h00);
    done("reset");
    for (int m = 0; m < 8; m++) begin
      wrr(11'h402, {3'(m), 5'h00});
      rdc("mode", 11'h402, {3'(m), 5'h01});
    end
    rdc("cfga", 11'h400, 8'h10);
    wrr(11'h400, 8'hff);
    rdc("cfga", 11'h400, 8'h10);
    done("modes");
    wrr(11'h402, 8'hc0);
    for (int i = 0; i < 16; i++) begin
      wrr(11'h400, 8'h30 | 8'(i));
      if (i == 0) rdc("ecr", 11'h402, 8'hc0);
    end
    rdc("ecr", 11'h402, 8'hc2);
    for (int i = 0; i < 16; i++) rdc("fifo", 11'h400, 8'h30 | 8'(i));
    rdc("ecr", 11'h402, 8'hc1);
    done("fifo");
    wrr(11'h402, 8'h00);
    wrr(11'h000, 8'ha5);
    chk("pd", pdo, 8'ha5);
    rdc("data", 11'h000, 8'ha5);
    wrr(11'h002, 8'h24);
    chk("oe", {7'h00, oe}, 8'h01);
    chk("init", {7'h00, init_n}, 8'h01);
    wrr(11'h402, 8'h20);
    chk("oe", {7'h00, oe}, 8'h00);
    rdc("data", 11'h000, 8'h3c);
    wrr(11'h002, 8'h00);
    done("standard");
    // compatibility fifo drained by the hardware strobe, then burst forward
    wrr(11'h402, 8'h48);
    chk("dma", {7'h00, dreq}, 8'h01);
    rdc("ecr", 11'h402, 8'h4d);
    busy <= 1'b0;
    wrr(11'h400, 8'h96);
    stb_wait();
    chk("cpd", pdo, 8'h96);
    wrr(11'h402, 8'h60);
    wrr(11'h000, 8'h05);
    stb_wait();
    chk("apd", pdo, 8'h05);
    chk("atag", {7'h00, ds_n}, 8'h00);
    busy <= 1'b1;
    done("handshake");
    wrr(11'h403, 8'h01);
    wrr(11'h402, 8'h80);
    rdc("stat", 11'h001, 8'h2e);
    // address write first, then data, reads of both ports
    for (int k = 0; k < 4; k++) begin
      bus(!k[0], k[1] ? 11'h004 : 11'h003, 8'h40 | 8'(k), q);
      if (!k[0]) begin
        chk("cap", cap, 8'h40 | 8'(k));
        chk("kind", {7'h00, cap_a}, {7'h00, !k[1]});
      end else
        chk("erd", q, 8'h3c);
    end
    hold <= 1'b1;
    @(posedge clk);
    fork
      bus(1'b1, 11'h004, 8'h5a, q);
      begin
        repeat (6) @(posedge clk);
        chk("holdoff", {7'h00, ds_n}, 8'h01);
        hold <= 1'b0;
      end
    join
    chk("cap", cap, 8'h5a);
    done("enhanced");
    mute <= 1'b1;
    bus(1'b1, 11'h004, 8'h77, q);
    chk("tmo_lat", 8'(lat > 20), 8'h01);
    mute <= 1'b0;
    rdc("tmo", 11'h001, 8'h2f);
    wrr(11'h001, 8'h00);
    rdc("tmo", 11'h001, 8'h2f);
    wrr(11'h001, 8'h01);
    rdc("tmo", 11'h001, 8'h2e);
    done("timeout");
    wrr(11'h403, 8'h03);
    hold <= 1'b1;
    @(posedge clk);
    fork
      bus(1'b1, 11'h004, 8'h6b, q);
      begin
        repeat (6) @(posedge clk);
        chk("start", {7'h00, ds_n}, 8'h00);
        hold <= 1'b0;
      end
    join
    chk("cap", cap, 8'h6b);
    done("older");
    conclude();
  end
endmodule
`default_nettype wire
